/* rtl/avmsc_ctrl.sv */
/*
  Start-up sequencing, status, soft volume, mute, auto mute, de-emphasis select
  and clip indicator for a six-channel modulator.
  Assumes a register port from the serial control interface decoder and
  same-clock sample and clip flags from the modulator datapath.
*/
`timescale 1ns/1ps
module avmsc_ctrl
  import avmsc_pkg::*;
#(
  parameter int TICK_LEN = avmsc_pkg::TICK_CYCLES,
  parameter logic [7:0] DEVICE_ID = 8'hA5 // Arbitrary value
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic reset_n_pin,
  input wire logic power_down_n,
  input wire logic mclk_in,
  input wire logic lrclk_in,
  input wire logic mute_n_pin,
  input wire logic pll_lock,
  input wire logic err_recovery_n,
  input wire logic sample_strobe,
  input wire logic [5:0] ch_sample_nonzero,
  input wire logic [5:0] clip_detect,
  input wire logic ctl_wr_en,
  input wire logic [7:0] ctl_addr,
  input wire logic [7:0] ctl_wdata,
  output logic [7:0] ctl_rdata,
  output logic [5:0] ch_valid,
  output logic [47:0] ch_gain,
  output logic deemph_enable,
  output logic [1:0] deemph_rate,
  output logic clip_n
);
  typedef struct packed {
    avmsc_pwr_t pwr;
    logic slow;
    logic [6:0] start_ms;
    logic [31:0] tick_cnt;
    logic tick;
    logic mclk_prev;
    logic lrclk_prev;
    logic [6:0] idle_cnt;
    logic [4:0] lead_cnt;
    logic [1:0] mute_cnt;
    logic [8:0] frame_cnt;
    logic frame_err;
    logic [7:0] deemph_cnt;
    logic [2:0] hold_ms;
    logic [3:0] clip_ms;
    logic clip_hold;
    logic [7:0] sys_ctl;
    logic [7:0] am_dly;
    logic [5:0] ch_mute;
    logic [5:0][7:0] gain;
    logic [5:0][5:0] zero_ms;
    logic [5:0][1:0] nz_run;
    logic [5:0] automuted;
    logic [5:0] valid;
    logic [1:0] deemph;
    logic [7:0] rdata;
  } avmsc_state_t;

  avmsc_state_t st_reg;
  avmsc_state_t st_next;

  logic [5:0] pins_s;
  logic reset_n_s;
  logic pdn_n_s;
  logic mclk_s;
  logic lrclk_s;
  logic mute_n_s;
  logic lock_s;
  logic err_s;
  logic mclk_edge;
  logic lrclk_edge;
  logic mclk_active;
  logic pin_mute;
  logic deemph_busy;
  logic running;
  logic hard_mute;
  logic [5:0] ch_muted;
  logic [5:0] ramp_start;
  logic [5:0] ramp_busy;
  logic [5:0][7:0] ramp_gain;
  logic [5:0][7:0] ramp_to;
  logic [5:0][7:0] desired;
  logic [7:0] status;

  avmsc_pin_sync #(.W(6)) u_sync (
    .sys_clk(sys_clk),
    .rst(rst),
    .pin_async({err_recovery_n, pll_lock, mute_n_pin, lrclk_in, mclk_in, power_down_n}),
    .pin_sync(pins_s)
  );

  // Device reset pin kept separate so its lead over power-down can be measured
  avmsc_pin_sync #(.W(1)) u_sync_rst (
    .sys_clk(sys_clk),
    .rst(rst),
    .pin_async(reset_n_pin),
    .pin_sync(reset_n_s)
  );

  assign pdn_n_s = pins_s[0];
  assign mclk_s = pins_s[1];
  assign lrclk_s = pins_s[2];
  assign mute_n_s = pins_s[3];
  assign lock_s = pins_s[4];
  assign err_s = ~pins_s[5];
  assign mclk_edge = mclk_s & ~st_reg.mclk_prev;
  assign lrclk_edge = lrclk_s & ~st_reg.lrclk_prev;
  assign mclk_active = (int'(st_reg.idle_cnt) < MCLK_IDLE_CYCLES);
  assign pin_mute = (int'(st_reg.mute_cnt) >= MUTE_PIN_MCLK);
  assign deemph_busy = (st_reg.deemph_cnt != 8'h00);
  assign running = (st_reg.pwr == PWR_RUN);
  // Recovery forces gains to mute; on exit they ramp to the mute-dictated target
  assign hard_mute = ~running | err_s;

  genvar gi;
  generate
    for (gi = 0; gi < NUM_CH; gi++) begin : g_ch
      // Mute sources share one quiet path: pin, control bit, de-emphasis reload, channel bit
      assign ch_muted[gi] = pin_mute | st_reg.sys_ctl[SYS_MUTE_BIT] | deemph_busy | st_reg.ch_mute[gi];
      assign desired[gi] = ch_muted[gi] ? GAIN_MUTE_CODE : st_reg.gain[gi];
      // Only channels whose target moved start; the latest write is the next value
      assign ramp_start[gi] = ~hard_mute & (desired[gi] != ramp_to[gi]) &
                              (ch_muted[gi] | (st_reg.hold_ms == 3'd0));
      avmsc_gain_ramp u_ramp (
        .sys_clk(sys_clk),
        .rst(rst),
        .tick(st_reg.tick),
        .hard_mute(hard_mute),
        .start(ramp_start[gi]),
        .target(desired[gi]),
        .gain(ramp_gain[gi]),
        .gain_target(ramp_to[gi]),
        .busy(ramp_busy[gi])
      );
    end
  endgenerate

  always_comb begin
    status = 8'h00;
    status[ST_VOL_BUSY] = |ramp_busy;
    status[ST_NO_ERR] = (&st_reg.valid) & ~st_reg.frame_err & lock_s & mclk_active & ~err_s;
    status[ST_FRAME_ERR] = st_reg.frame_err;
    status[ST_MCLK_ERR] = ~lock_s | ~mclk_active;
  end

  always_comb begin
    logic wr_ok;
    logic [7:0] gidx;
    wr_ok = 1'b0;
    gidx = 8'h00;
    st_next = st_reg;
    st_next.mclk_prev = mclk_s;
    st_next.lrclk_prev = lrclk_s;

    // Millisecond tick
    st_next.tick = 1'b0;
    if (int'(st_reg.tick_cnt) >= TICK_LEN - 1) begin
      st_next.tick_cnt = '0;
      st_next.tick = 1'b1;
    end else begin
      st_next.tick_cnt = st_reg.tick_cnt + 32'd1;
    end

    // Master clock activity and mute pin qualification
    if (mclk_edge) begin
      st_next.idle_cnt = '0;
    end else if (mclk_active) begin
      st_next.idle_cnt = st_reg.idle_cnt + 7'd1;
    end
    if (mute_n_s) begin
      st_next.mute_cnt = '0;
    end else if (mclk_edge && !pin_mute) begin
      st_next.mute_cnt = st_reg.mute_cnt + 2'd1;
    end

    // Frame length check
    if (lrclk_edge) begin
      st_next.frame_cnt = '0;
      st_next.frame_err = ~frame_ok(st_reg.frame_cnt, st_reg.sys_ctl[SYS_MCLK256_BIT]);
      if (deemph_busy) begin
        st_next.deemph_cnt = st_reg.deemph_cnt - 8'd1;
      end
    end else if (mclk_edge && st_reg.frame_cnt != 9'h1FF) begin
      st_next.frame_cnt = st_reg.frame_cnt + 9'd1;
    end

    // Power sequencing
    case (st_reg.pwr)
      PWR_DOWN: begin
        if (!reset_n_s) begin
          st_next.lead_cnt = '0;
        end else if (!pdn_n_s && mclk_edge && int'(st_reg.lead_cnt) < RESET_LEAD_MCLK) begin
          st_next.lead_cnt = st_reg.lead_cnt + 5'd1;
        end
        if (reset_n_s && pdn_n_s) begin
          st_next.slow = (int'(st_reg.lead_cnt) >= RESET_LEAD_MCLK);
          st_next.start_ms = (int'(st_reg.lead_cnt) >= RESET_LEAD_MCLK) ?
                             7'(SLOW_START_MS) : 7'(FAST_START_MS);
          st_next.pwr = mclk_active ? PWR_STARTUP : PWR_WAIT_CLK;
        end
      end
      PWR_WAIT_CLK: begin
        if (mclk_active) begin
          st_next.slow = 1'b0;
          st_next.start_ms = 7'(FAST_START_MS);
          st_next.pwr = PWR_STARTUP;
        end
      end
      PWR_STARTUP: begin
        if (st_reg.tick) begin
          st_next.start_ms = st_reg.start_ms - 7'd1;
          if (st_reg.start_ms == 7'd1) begin
            st_next.pwr = PWR_RUN;
          end
        end
      end
      PWR_RUN: begin
      end
      default: begin
        st_next.pwr = PWR_DOWN;
      end
    endcase
    if (!reset_n_s || !pdn_n_s) begin
      st_next.pwr = PWR_DOWN;
      st_next.lead_cnt = (!reset_n_s) ? 5'd0 : st_next.lead_cnt;
    end

    // Gain write hold-off
    if (st_reg.tick && st_reg.hold_ms != 3'd0) begin
      st_next.hold_ms = st_reg.hold_ms - 3'd1;
    end

    // Register writes, ignored while powered down or held in reset
    wr_ok = ctl_wr_en & reset_n_s & pdn_n_s;
    gidx = ctl_addr - REG_GAIN_BASE;
    if (wr_ok) begin
      if (ctl_addr == REG_SYS_CTL) begin
        st_next.sys_ctl = ctl_wdata;
        if (ctl_wdata[SYS_DEEMPH_HI_BIT:SYS_DEEMPH_LO_BIT] !=
            st_reg.sys_ctl[SYS_DEEMPH_HI_BIT:SYS_DEEMPH_LO_BIT]) begin
          st_next.deemph_cnt = 8'(DEEMPH_INIT_FRAMES);
        end
      end else if (ctl_addr == REG_AUTOMUTE_DLY) begin
        st_next.am_dly = ctl_wdata;
      end else if (ctl_addr == REG_CH_MUTE) begin
        st_next.ch_mute = ctl_wdata[5:0];
      end else if (ctl_addr >= REG_GAIN_BASE && int'(gidx) < NUM_CH) begin
        st_next.gain[gidx[2:0]] = ctl_wdata;
        st_next.hold_ms = 3'(GAIN_HOLD_MS);
      end
    end

    // Auto mute per channel
    for (int i = 0; i < NUM_CH; i++) begin
      if (sample_strobe && ch_sample_nonzero[i]) begin
        st_next.zero_ms[i] = '0;
        st_next.nz_run[i] = (st_reg.nz_run[i] == 2'd2) ? 2'd2 : st_reg.nz_run[i] + 2'd1;
      end else begin
        if (sample_strobe) begin
          st_next.nz_run[i] = '0;
        end
        if (st_reg.tick && st_reg.zero_ms[i] != 6'h3F) begin
          st_next.zero_ms[i] = st_reg.zero_ms[i] + 6'd1;
        end
      end
      if (!st_reg.sys_ctl[SYS_AUTOMUTE_EN_BIT]) begin
        st_next.automuted[i] = 1'b0;
      end else if (st_reg.zero_ms[i] >= clamp_dly(st_reg.am_dly)) begin
        st_next.automuted[i] = 1'b1;
      end else if (st_reg.nz_run[i] == 2'd2) begin
        st_next.automuted[i] = 1'b0;
      end
      // Valid drops at once on hard mute or auto mute; for a muted channel, only once it has ramped fully down
      st_next.valid[i] = ~hard_mute & ~st_reg.automuted[i] &
                         ~(ch_muted[i] & ~ramp_busy[i] & (ramp_gain[i] == GAIN_MUTE_CODE));
    end

    // Clip indicator; a new clip beats the periodic clear
    if (st_reg.tick) begin
      st_next.clip_ms = (st_reg.clip_ms == 4'd1) ? 4'(CLIP_CLEAR_MS) : st_reg.clip_ms - 4'd1;
      if (st_reg.clip_ms == 4'd1) begin
        st_next.clip_hold = 1'b0;
      end
    end
    if (|clip_detect && running) begin
      st_next.clip_hold = 1'b1;
    end

    st_next.deemph = st_reg.sys_ctl[SYS_DEEMPH_HI_BIT:SYS_DEEMPH_LO_BIT];

    // Read data
    if (ctl_addr == REG_STATUS) begin
      st_next.rdata = status;
    end else if (ctl_addr == REG_ID) begin
      st_next.rdata = DEVICE_ID;
    end else if (ctl_addr == REG_SYS_CTL) begin
      st_next.rdata = st_reg.sys_ctl;
    end else if (ctl_addr == REG_AUTOMUTE_DLY) begin
      st_next.rdata = st_reg.am_dly;
    end else if (ctl_addr == REG_CH_MUTE) begin
      st_next.rdata = {2'b00, st_reg.ch_mute};
    end else if (ctl_addr >= REG_GAIN_BASE && int'(gidx) < NUM_CH) begin
      st_next.rdata = st_reg.gain[gidx[2:0]];
    end else begin
      st_next.rdata = 8'h00;
    end

    // Device reset pin restores defaults and hard-mutes at once
    if (!reset_n_s) begin
      st_next.sys_ctl = SYS_CTL_RESET;
      st_next.am_dly = AUTOMUTE_DLY_RESET;
      st_next.ch_mute = '0;
      st_next.gain = {NUM_CH{GAIN_RESET}};
      st_next.deemph_cnt = '0;
      st_next.hold_ms = '0;
      st_next.valid = '0;
      st_next.clip_hold = 1'b0;
    end else if (hard_mute) begin
      st_next.valid = '0;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      st_reg <= '0;
      st_reg.pwr <= PWR_DOWN;
      st_reg.idle_cnt <= 7'(MCLK_IDLE_CYCLES);
      st_reg.sys_ctl <= SYS_CTL_RESET;
      st_reg.am_dly <= AUTOMUTE_DLY_RESET;
      st_reg.gain <= {NUM_CH{GAIN_RESET}};
      st_reg.clip_ms <= 4'(CLIP_CLEAR_MS);
    end else begin
      st_reg <= st_next;
    end
  end

  always_comb begin
    for (int i = 0; i < NUM_CH; i++) begin
      ch_gain[i*8 +: 8] = ramp_gain[i];
    end
  end

  assign ctl_rdata = st_reg.rdata;
  assign ch_valid = st_reg.valid;
  assign deemph_enable = (st_reg.deemph != 2'b00);
  assign deemph_rate = st_reg.deemph;
  assign clip_n = ~st_reg.clip_hold;
endmodule

/* rtl/avmsc_pkg.sv */
/*
  Constants, types and helpers shared by the volume, mute and status controller.
  Assumes a 250 MHz system clock and a host register port fed by the serial
  control interface decoder.
*/
package avmsc_pkg;
  localparam int NUM_CH = 6;
  localparam int CLK_PERIOD_NS = 4;
  localparam int TICK_NS = 1_000_000;
  localparam int TICK_CYCLES = TICK_NS / CLK_PERIOD_NS;
  // Millisecond counts; N ticks span (N-1, N] ms
  localparam int SLOW_START_MS = 100;
  localparam int FAST_START_MS = 5;
  localparam int GAIN_HOLD_MS = 5;
  localparam int CLIP_CLEAR_MS = 10;
  localparam int RAMP_MS = 64;
  localparam int RAMP_SHIFT = 12;
  localparam int AUTOMUTE_MIN_MS = 5;
  localparam int AUTOMUTE_MAX_MS = 50;
  localparam int RESET_LEAD_MCLK = 16;
  localparam int MUTE_PIN_MCLK = 3;
  localparam int FRAME_TOL = 10;
  localparam int FRAME_SHORT = 128;
  localparam int FRAME_LONG = 256;
  localparam int DEEMPH_INIT_FRAMES = 128;
  localparam int MCLK_IDLE_CYCLES = 64;
  localparam logic [7:0] REG_STATUS = 8'h00;
  localparam logic [7:0] REG_ID = 8'h01;
  localparam logic [7:0] REG_SYS_CTL = 8'h02;
  localparam logic [7:0] REG_AUTOMUTE_DLY = 8'h03;
  localparam logic [7:0] REG_CH_MUTE = 8'h04;
  localparam logic [7:0] REG_GAIN_BASE = 8'h08;
  localparam int SYS_MUTE_BIT = 0;
  localparam int SYS_AUTOMUTE_EN_BIT = 1;
  localparam int SYS_DEEMPH_LO_BIT = 2;
  localparam int SYS_DEEMPH_HI_BIT = 3;
  localparam int SYS_MCLK256_BIT = 4;
  localparam logic [7:0] SYS_CTL_RESET = 8'h12;
  localparam logic [7:0] AUTOMUTE_DLY_RESET = 8'h05;
  localparam int ST_VOL_BUSY = 0;
  localparam int ST_NO_ERR = 1;
  localparam int ST_FRAME_ERR = 2;
  localparam int ST_MCLK_ERR = 3;
  // Code FF is +24 dB, half-dB per code down to 0F (-96 dB), coarser below, 00 mute
  localparam logic [7:0] GAIN_MUTE_CODE = 8'h00;
  localparam logic [7:0] GAIN_0DB_CODE = 8'hCF;
  localparam logic [7:0] GAIN_RESET = GAIN_0DB_CODE;

  typedef enum logic [1:0] {PWR_DOWN, PWR_WAIT_CLK, PWR_STARTUP, PWR_RUN} avmsc_pwr_t;

  function automatic logic frame_ok(input logic [8:0] cnt, input logic long_frame);
    int exp;
    begin
      exp = long_frame ? FRAME_LONG : FRAME_SHORT;
      frame_ok = (int'(cnt) >= exp - FRAME_TOL) && (int'(cnt) <= exp + FRAME_TOL);
    end
  endfunction

  function automatic logic [5:0] clamp_dly(input logic [7:0] v);
    begin
      if (int'(v) < AUTOMUTE_MIN_MS) begin
        clamp_dly = 6'(AUTOMUTE_MIN_MS);
      end else if (int'(v) > AUTOMUTE_MAX_MS) begin
        clamp_dly = 6'(AUTOMUTE_MAX_MS);
      end else begin
        clamp_dly = v[5:0];
      end
    end
  endfunction
endpackage

/* rtl/avmsc_pin_sync.sv */
/*
  Three-stage pin synchroniser; an output changes only when stages two and three agree.
  Assumes pins are asynchronous to sys_clk and change slower than a few cycles.
*/
`timescale 1ns/1ps
module avmsc_pin_sync #(
  parameter int W = 1
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic [W-1:0] pin_async,
  output logic [W-1:0] pin_sync
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;
    logic [W-1:0] stable;
  } avmsc_sync_t;

  avmsc_sync_t st_reg;
  avmsc_sync_t st_next;

  always_comb begin
    st_next = st_reg;
    st_next.s1 = pin_async;
    st_next.s2 = st_reg.s1;
    st_next.s3 = st_reg.s2;
    // Disagreeing bits hold their last settled value
    st_next.stable = (st_reg.s2 & st_reg.s3) | (st_reg.stable & (st_reg.s2 ^ st_reg.s3));
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign pin_sync = st_reg.stable;
endmodule

/* rtl/avmsc_gain_ramp.sv */
/*
  One channel soft gain ramp: second-order s-curve over a fixed number of ms ticks.
  Assumes a one-cycle tick each millisecond and starts only while idle.
*/
`timescale 1ns/1ps
module avmsc_gain_ramp
  import avmsc_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic tick,
  input wire logic hard_mute,
  input wire logic start,
  input wire logic [7:0] target,
  output logic [7:0] gain,
  output logic [7:0] gain_target,
  output logic busy
);
  typedef struct packed {
    logic [7:0] cur;
    logic [7:0] from;
    logic [7:0] to;
    logic [6:0] step;
    logic busy;
  } avmsc_ramp_t;

  avmsc_ramp_t st_reg;
  avmsc_ramp_t st_next;

  // Accelerate over the first half, mirror over the second
  function automatic logic [13:0] s_curve(input logic [6:0] t);
    int r;
    begin
      r = RAMP_MS - int'(t);
      if (int'(t) < RAMP_MS / 2) begin
        s_curve = 14'(2 * int'(t) * int'(t));
      end else begin
        s_curve = 14'((RAMP_MS * RAMP_MS) - 2 * r * r);
      end
    end
  endfunction

  always_comb begin
    logic [6:0] t;
    logic signed [9:0] delta;
    logic signed [23:0] prod;
    logic signed [11:0] sum;
    t = st_reg.step + 7'd1;
    delta = $signed({2'b00, st_reg.to}) - $signed({2'b00, st_reg.from});
    prod = delta * $signed({1'b0, s_curve(t)});
    sum = $signed({4'b0000, st_reg.from}) + 12'(prod >>> RAMP_SHIFT);
    st_next = st_reg;
    if (hard_mute) begin
      st_next = '0;
    end else if (st_reg.busy) begin
      if (tick) begin
        st_next.step = t;
        st_next.cur = sum[7:0];
        if (int'(t) == RAMP_MS) begin
          st_next.cur = st_reg.to;
          st_next.busy = 1'b0;
        end
      end
    end else if (start) begin
      st_next.from = st_reg.cur;
      st_next.to = target;
      st_next.step = '0;
      st_next.busy = (target != st_reg.cur);
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign gain = st_reg.cur;
  assign gain_target = st_reg.to;
  assign busy = st_reg.busy;
endmodule

/* tb/avmsc_ctrl_sva.sv */
/* Port checker for avmsc_ctrl, bound at the foot of this file.
   Assumes one sys_clk domain and the bench's shortened ms tick. */
`timescale 1ns/1ps
module avmsc_ctrl_sva
  import avmsc_pkg::*;
#(
  parameter int TICK_LEN = 20,
  parameter logic [7:0] DEVICE_ID = 8'hA5 // Arbitrary value
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic reset_n_pin,
  input wire logic [5:0] clip_detect,
  input wire logic [7:0] ctl_addr,
  input wire logic [7:0] ctl_rdata,
  input wire logic [5:0] ch_valid,
  input wire logic [47:0] ch_gain,
  input wire logic deemph_enable,
  input wire logic [1:0] deemph_rate,
  input wire logic clip_n
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);
  int unsigned clip_low_reg;
  // Counts clip-low cycles since the last overrange
  always_ff @(posedge sys_clk) begin
    if (rst || clip_n || (|clip_detect)) begin
      clip_low_reg <= 0;
    end else begin
      clip_low_reg <= clip_low_reg + 1;
    end
  end
  chk_reset_outputs_quiet: assert property (disable iff (1'b0) rst |=> ch_valid == 6'h00 && ch_gain == 48'h0)
    else $error("outputs live after reset");
  chk_reset_clip_idle: assert property (disable iff (1'b0) rst |=> clip_n && ctl_rdata == 8'h00)
    else $error("clip or read data set after reset");
  chk_pin_reset_mute: assert property (!reset_n_pin [*6] |=> ch_valid == 6'h00 && ch_gain == 48'h0)
    else $error("pin reset left outputs live");
  chk_deemph_decode: assert property (deemph_enable == (deemph_rate != 2'b00))
    else $error("filter enable disagrees with rate");
  chk_unmapped_read: assert property (ctl_addr == 8'h20 |=> ctl_rdata == 8'h00)
    else $error("unmapped read not zero");
  chk_id_read: assert property (ctl_addr == REG_ID && reset_n_pin |=> ctl_rdata == DEVICE_ID)
    else $error("identity read wrong");
  chk_clip_set: assert property ((|clip_detect) && ch_valid != 6'h00 |-> ##[1:3] !clip_n)
    else $error("clip not flagged");
  chk_clip_clear: assert property (clip_low_reg <= 10 * TICK_LEN + 8)
    else $error("clip not cleared in time");
  cover property (ch_valid == 6'h3F);
  cover property ($fell(clip_n));
  cover property (deemph_enable);
endmodule

bind avmsc_ctrl avmsc_ctrl_sva #(.TICK_LEN(TICK_LEN), .DEVICE_ID(DEVICE_ID)) u_sva (.sys_clk(sys_clk), .rst(rst),
  .reset_n_pin(reset_n_pin), .clip_detect(clip_detect), .ctl_addr(ctl_addr), .ctl_rdata(ctl_rdata),
  .ch_valid(ch_valid), .ch_gain(ch_gain), .deemph_enable(deemph_enable), .deemph_rate(deemph_rate), .clip_n(clip_n));

/* tb/avmsc_host_model.sv */
/* Host on the register port: single writes and reads with one-cycle lag.
   Assumes the bench calls its tasks from one thread only. */
`timescale 1ns/1ps
module avmsc_host_model (
  input wire logic sys_clk,
  output logic ctl_wr_en,
  output logic [7:0] ctl_addr,
  output logic [7:0] ctl_wdata,
  input wire logic [7:0] ctl_rdata
);
  initial begin
    ctl_wr_en = 1'b0;
    ctl_addr = 8'h00;
    ctl_wdata = 8'h00;
  end
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    ctl_wr_en <= 1'b1;
    ctl_addr <= a;
    ctl_wdata <= d;
    @(posedge sys_clk);
    ctl_wr_en <= 1'b0;
    ctl_wdata <= ~d; // Stale data never repeats the write
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] q);
    @(posedge sys_clk);
    ctl_addr <= a;
    @(posedge sys_clk);
    @(posedge sys_clk);
    q = ctl_rdata;
  endtask
endmodule

/* tb/tb_top.sv */
/* Self-checking bench for avmsc_ctrl driven through a host model.
   Assumes a 20-cycle ms tick; mclk is sys_clk/4 and a frame is 256 mclk. */
`timescale 1ns/1ps
module tb_top;
  import avmsc_pkg::*;
  localparam int T = 20;
  localparam logic [7:0] ID = 8'h5A; // Arbitrary value
  logic sys_clk, rst, reset_n_pin, power_down_n, mute_n_pin, pll_lock, sample_strobe, ctl_wr_en, err_n;
  logic deemph_enable, clip_n;
  logic [5:0] nz_mask, clip_detect, ch_valid;
  logic [9:0] div_cnt;
  logic [7:0] ctl_addr, ctl_wdata, ctl_rdata, q, g, h;
  logic [47:0] ch_gain;
  logic [1:0] deemph_rate;
  int mismatches, checks_done, c;
  avmsc_ctrl #(.TICK_LEN(T), .DEVICE_ID(ID)) uut (.sys_clk(sys_clk), .rst(rst), .reset_n_pin(reset_n_pin),
    .power_down_n(power_down_n), .mclk_in(div_cnt[1]), .lrclk_in(div_cnt[9]), .mute_n_pin(mute_n_pin),
    .pll_lock(pll_lock), .err_recovery_n(err_n), .sample_strobe(sample_strobe), .ch_sample_nonzero(nz_mask),
    .clip_detect(clip_detect), .ctl_wr_en(ctl_wr_en), .ctl_addr(ctl_addr), .ctl_wdata(ctl_wdata),
    .ctl_rdata(ctl_rdata), .ch_valid(ch_valid), .ch_gain(ch_gain), .deemph_enable(deemph_enable),
    .deemph_rate(deemph_rate), .clip_n(clip_n));
  avmsc_host_model host (.sys_clk(sys_clk), .ctl_wr_en(ctl_wr_en), .ctl_addr(ctl_addr),
    .ctl_wdata(ctl_wdata), .ctl_rdata(ctl_rdata));
  initial begin
    sys_clk = 1'b0;
    forever #2 sys_clk = ~sys_clk;
  end
  always @(posedge sys_clk) begin
    div_cnt <= div_cnt + 10'h001;
    sample_strobe <= ($urandom % 4) == 0;
  end
  // Valids expected with one channel held muted
  function automatic logic [5:0] live_mask(input int n);
    live_mask = 6'h3F & ~(6'h01 << n);
  endfunction
  // Wide enough for valids and all gains together
  task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
    checks_done++;
    if (seen !== exp) begin
      mismatches++;
      $display("BAD t=%0t seen %h want %h", $time, seen, exp);
    end
  endtask
  task automatic ms(input int n);
    repeat (n * T) @(posedge sys_clk);
  endtask
  task automatic test_done();
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  initial begin
    repeat (40000) @(posedge sys_clk);
    mismatches++;
    test_done();
  end
  initial begin
    void'($urandom(32'h48db));
    rst = 1'b1;
    reset_n_pin = 1'b1;
    power_down_n = 1'b0;
    mute_n_pin = 1'b1;
    pll_lock = 1'b1;
    err_n = 1'b1;
    sample_strobe = 1'b0;
    clip_detect = 6'h00;
    nz_mask = 6'h3F;
    div_cnt = 10'h000;
    mismatches = 0;
    checks_done = 0;
    repeat (10) @(posedge sys_clk);
    rst <= 1'b0;
    chk({ch_gain, ch_valid, clip_n}, 1);
    ms(4);
    power_down_n <= 1'b1;
    ms(90);
    chk(ch_valid, 6'h00);
    ms(12);
    chk(ch_valid, 6'h3F);
    ms(70);
    chk(ch_gain, {6{GAIN_0DB_CODE}});
    host.rd(REG_STATUS, q);
    chk(q, 8'h02);
    host.rd(REG_ID, q);
    chk(q, ID);
    host.rd(8'h20, q);
    chk(q, 8'h00);
    g = 8'h10 + 8'($urandom % 224);
    // A target equal to the current gain would start no ramp
    if (g == GAIN_0DB_CODE) begin
      g = 8'h11;
    end
    h = {g[6:0], 1'b1};
    host.wr(REG_GAIN_BASE, g);
    host.rd(REG_GAIN_BASE, q);
    chk(q, g);
    ms(3);
    host.rd(REG_STATUS, q);
    chk(q[0], 1'b0);
    ms(3);
    host.rd(REG_STATUS, q);
    chk(q[0], 1'b1);
    host.wr(REG_GAIN_BASE, 8'h20);
    host.wr(REG_GAIN_BASE, h);
    ms(150);
    chk(ch_gain[15:0], {GAIN_0DB_CODE, h});
    host.rd(REG_STATUS, q);
    chk(q[0], 1'b0);
    for (int i = 0; i < 2; i++) begin
      if (i == 0) begin
        host.wr(REG_SYS_CTL, SYS_CTL_RESET | 8'h01);
      end else begin
        mute_n_pin <= 1'b0;
      end
      ms(70);
      chk({ch_valid, ch_gain}, 0);
      err_n <= 1'b0;
      repeat (20) @(posedge sys_clk);
      chk(ch_valid, 6'h00);
      err_n <= 1'b1;
      ms(20);
      chk({ch_valid, ch_gain}, 0);
      host.wr(REG_SYS_CTL, SYS_CTL_RESET);
      mute_n_pin <= 1'b1;
      ms(75);
      chk({ch_valid, ch_gain[7:0]}, {6'h3F, h});
    end
    c = $urandom % 6;
    host.wr(REG_CH_MUTE, 8'h01 << c);
    ms(70);
    chk(ch_valid, live_mask(c));
    host.wr(REG_CH_MUTE, 8'h00);
    ms(70);
    chk(ch_valid, 6'h3F);
    host.wr(REG_AUTOMUTE_DLY, 8'h03);
    nz_mask <= 6'h3B;
    ms(3);
    chk(ch_valid, 6'h3F);
    ms(4);
    chk(ch_valid, 6'h3B);
    nz_mask <= 6'h3F;
    ms(2);
    chk(ch_valid, 6'h3F);
    clip_detect <= 6'h01 << c;
    @(posedge sys_clk);
    clip_detect <= 6'h00;
    repeat (1) @(posedge sys_clk);
    chk(clip_n, 1'b0);
    ms(11);
    chk(clip_n, 1'b1);
    pll_lock <= 1'b0;
    ms(1);
    host.rd(REG_STATUS, q);
    chk(q[3:1], 3'b100);
    pll_lock <= 1'b1;
    host.wr(REG_SYS_CTL, 8'h02);
    repeat (1100) @(posedge sys_clk);
    host.rd(REG_STATUS, q);
    chk(q[3:1], 3'b010);
    reset_n_pin <= 1'b0;
    repeat (20) @(posedge sys_clk);
    chk({ch_valid, ch_gain}, 0);
    reset_n_pin <= 1'b1;
    ms(3);
    chk(ch_valid, 6'h00);
    ms(4);
    chk(ch_valid, 6'h3F);
    host.rd(REG_GAIN_BASE, q);
    chk(q, GAIN_0DB_CODE);
    ms(66);
    for (int k = 1; k < 5; k++) begin
      host.wr(REG_SYS_CTL, SYS_CTL_RESET | {4'h0, 2'(k), 2'b00});
      ms(1);
      chk({deemph_enable, deemph_rate}, {2'(k) != 2'b00, 2'(k)});
      chk(ch_valid, 6'h3F);
    end
    ms(66);
    chk({ch_valid, ch_gain}, 0);
    test_done();
  end
endmodule
